// [sws_params.svh]
`ifndef SWS_PARAMS_SVH
`define SWS_PARAMS_SVH
`define SWS_NPORT        4
`define SWS_UP_PORT      0
`define SWS_PAIR_PORT    1
`define SWS_TS_W         16
`define SWS_QDEPTH       32
`define SWS_FIFO_DEPTH   4
`define SWS_WIDTH_W      4
`define SWS_CORE_MHZ     250
`define SWS_DCP_MAX_CYC  5
`define SWS_PPCTD_RST    1'b1
`define SWS_RODIS_RST    1'b0
`endif

// [sws_pkg.sv]
`include "sws_params.svh"
package sws_pkg;
   typedef enum logic [1:0] {SWS_Q_P, SWS_Q_NP, SWS_Q_CP, SWS_Q_INS} sws_queue_t;
   typedef enum logic [2:0] {SWS_RT_ADDR32, SWS_RT_ADDR64, SWS_RT_ID, SWS_RT_TCFG,
                             SWS_RT_ROOT, SWS_RT_BCAST, SWS_RT_LOCAL, SWS_RT_GATHER} sws_route_t;
   typedef enum logic {SWS_IDLE, SWS_BUSY} sws_xfer_t;
   typedef struct packed {
      logic [1:0] queue;
      logic [2:0] route;
      logic [1:0] dest;
      logic [9:0] size;
      logic       ro;
      logic       cls;
      logic       pme_ack;
   } sws_req_t;
   typedef struct packed {
      logic [`SWS_NPORT-1:0] dest;
      logic [9:0]            size;
      logic                  ro;
      logic                  cls;
      logic                  done;
      logic [`SWS_TS_W-1:0]  ts;
   } sws_desc_t;
endpackage : sws_pkg

// [sws_ingress.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sws_params.svh"
// ==========================================================
// Arrival FIFO
module sws_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         clk_in,       // Core clock
   input  wire logic         rst_in,       // Async reset
   input  wire logic         in_valid_in,  // Write request
   output logic              in_ready_out, // Not full
   input  wire logic [W-1:0] in_data_in,   // Write data
   output logic              out_valid_out,// Not empty
   input  wire logic         out_ready_in, // Drain
   output logic [W-1:0]      out_data_out  // Head word
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0]   cnt_reg, cnt_next;
   logic          push, pop;
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out  = mem[rd_reg];
   always_comb begin
      cnt_next = cnt_reg;
      if (push & ~pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop & ~push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg      <= '0;
         in_ready_out <= 1'b0;
      end else begin
         cnt_reg      <= cnt_next;
         in_ready_out <= (cnt_next < (AW+1)'(D));
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
         if (pop)  rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (push) mem[wr_reg] <= in_data_in;
   end
endmodule : sws_fifo

// ==========================================================
// Ingress frame buffer of one port
module sws_ingress
   import sws_pkg::*;
#(
   parameter int PORT_ID = 2,
   parameter int QDEPTH  = `SWS_QDEPTH,
   parameter int NP      = `SWS_NPORT,
   parameter int TSW     = `SWS_TS_W
) (
   input  wire logic              CLK_SYS_IN,       // Core clock
   input  wire logic              RESET_IN,         // Async reset, high
   input  wire logic              IN_VALID_IN,      // TLP descriptor offered
   output logic                   IN_READY_OUT,     // Descriptor taken
   input  wire logic [1:0]        IN_QUEUE_IN,      // Physical queue
   input  wire logic [2:0]        IN_ROUTE_IN,      // Routing method
   input  wire logic [1:0]        IN_DEST_IN,       // Target port index
   input  wire logic [9:0]        IN_SIZE_IN,       // Payload dwords
   input  wire logic              IN_RO_IN,         // Relaxed ordering attr
   input  wire logic              IN_INS_CP_IN,     // Insertion TLP is completion
   input  wire logic              IN_PME_ACK_IN,    // PME ack answer
   input  wire logic [3:0]        IN_DONE_IN,       // Tail TLP fully received
   input  wire logic              CT_CTRL_WR_IN,    // Cut-through ctrl write
   input  wire logic              CT_CTRL_DATA_IN,  // Pair cut-through disable
   input  wire logic              SW_CTRL_WR_IN,    // Switch ctrl write
   input  wire logic              SW_CTRL_DATA_IN,  // Relaxed ordering disable
   input  wire logic [3:0]        INGRESS_WIDTH_IN, // Negotiated lanes
   input  wire logic [4*NP-1:0]   EGRESS_WIDTH_IN,  // Lanes per port
   input  wire logic              PAIR_REV_BUSY_IN, // Opposite 0/1 transfer on
   input  wire logic              PAIR_BUSY_IN,     // Any 0/1 transfer on
   input  wire logic [2:0]        GRANT_IN,         // Scheduler grant P/NP/CP
   input  wire logic              EGRESS_END_IN,    // Granted TLP finished
   output logic [2:0]             HEAD_VALID_OUT,   // Dispatchable heads
   output logic [3*NP-1:0]        HEAD_DEST_OUT,    // Target port masks
   output logic [29:0]            HEAD_SIZE_OUT,    // Payload sizes
   output logic [3*TSW-1:0]       HEAD_AGE_OUT,     // Arrival timestamps
   output logic [2:0]             HEAD_CUT_OUT,     // Cut-through allowed
   output logic [2:0]             HEAD_DCP_OUT,     // Goes via decoupler
   output logic                   XFER_BUSY_OUT,    // Transfer in flight
   output logic                   PAIR_XFER_OUT,    // In-flight is 0/1 pair
   output logic                   LOCAL_TERM_OUT    // Message terminated here
);
   localparam int AW = $clog2(QDEPTH);
   localparam int FW = $bits(sws_req_t);

   function automatic logic older(input logic [TSW-1:0] a, input logic [TSW-1:0] b);
      logic [TSW-1:0] d;
      d = a - b;
      older = d[TSW-1];
   endfunction : older

   function automatic logic [NP-1:0] onehot(input int idx);
      onehot = '0;
      onehot[idx] = 1'b1;
   endfunction : onehot

   function automatic logic [NP-1:0] route_mask(input sws_req_t r);
      case (sws_route_t'(r.route))
         SWS_RT_ADDR32, SWS_RT_ADDR64, SWS_RT_ID, SWS_RT_TCFG: route_mask = onehot(int'(r.dest));
         SWS_RT_ROOT:   route_mask = onehot(`SWS_UP_PORT);
         SWS_RT_BCAST:  route_mask = (PORT_ID == `SWS_UP_PORT) ? ~onehot(`SWS_UP_PORT) : '0;
         SWS_RT_GATHER: route_mask = r.pme_ack ? onehot(`SWS_UP_PORT) : '0;
         default:       route_mask = '0;
      endcase
   endfunction : route_mask

   // ==========================================================
   // Control bits and timestamp
   logic           ppctd_reg, rodis_reg;
   logic [TSW-1:0] ts_reg;
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         ppctd_reg <= `SWS_PPCTD_RST;
         rodis_reg <= `SWS_RODIS_RST;
      end else begin
         if (CT_CTRL_WR_IN) ppctd_reg <= CT_CTRL_DATA_IN;
         if (SW_CTRL_WR_IN) rodis_reg <= SW_CTRL_DATA_IN;
      end
   end
   // One enqueue per cycle and a tick per cycle keep stamps unique until wrap
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) ts_reg <= '0;
      else          ts_reg <= ts_reg + 1'b1;
   end

   // ==========================================================
   // Arrival FIFO and enqueue
   logic     f_valid, f_ready;
   logic [FW-1:0] f_data;
   sws_req_t f_req, in_req;
   logic     term, enq;
   assign in_req = '{queue: IN_QUEUE_IN, route: IN_ROUTE_IN, dest: IN_DEST_IN,
                     size: IN_SIZE_IN, ro: IN_RO_IN, cls: IN_INS_CP_IN,
                     pme_ack: IN_PME_ACK_IN};
   sws_fifo #(.W(FW), .D(`SWS_FIFO_DEPTH)) u_fifo (
      .clk_in        (CLK_SYS_IN),
      .rst_in        (RESET_IN),
      .in_valid_in   (IN_VALID_IN),
      .in_ready_out  (IN_READY_OUT),
      .in_data_in    (in_req),
      .out_valid_out (f_valid),
      .out_ready_in  (f_ready),
      .out_data_out  (f_data)
   );
   assign f_req = sws_req_t'(f_data);

   sws_desc_t     mem [4][QDEPTH];
   logic [AW-1:0] wr_ptr [4];
   logic [AW-1:0] rd_ptr [4];
   logic [AW:0]   cnt    [4];
   logic          pop_en;
   logic [1:0]    pop_q;

   assign term    = (route_mask(f_req) == '0);
   assign f_ready = term | (cnt[f_req.queue] < (AW+1)'(QDEPTH));
   assign enq     = f_valid & f_ready & ~term;

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) LOCAL_TERM_OUT <= 1'b0;
      else          LOCAL_TERM_OUT <= f_valid & term;
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         for (int q = 0; q < 4; q++) begin
            wr_ptr[q] <= '0;
            rd_ptr[q] <= '0;
            cnt[q]    <= '0;
         end
      end else begin
         for (int q = 0; q < 4; q++) begin
            if (enq && f_req.queue == 2'(q)) wr_ptr[q] <= wr_ptr[q] + 1'b1;
            if (pop_en && pop_q == 2'(q))    rd_ptr[q] <= rd_ptr[q] + 1'b1;
            cnt[q] <= cnt[q] + (AW+1)'(enq && f_req.queue == 2'(q))
                             - (AW+1)'(pop_en && pop_q == 2'(q));
         end
      end
   end
   always_ff @(posedge CLK_SYS_IN) begin
      for (int q = 0; q < 4; q++) begin
         if (IN_DONE_IN[q] && cnt[q] != '0) mem[q][wr_ptr[q]-1'b1].done <= 1'b1;
      end
      if (enq) begin
         mem[f_req.queue][wr_ptr[f_req.queue]] <= '{dest: route_mask(f_req),
            size: f_req.size, ro: f_req.ro, cls: f_req.cls,
            done: 1'b0, ts: ts_reg};
      end
   end

   // ==========================================================
   // Logical heads and ordering
   sws_desc_t lh [3];
   logic [2:0] pres, lins, cand, cut, pair, upblk, dcp, ok;
   logic       ro_cp, np_ok, cp_ok;
   sws_xfer_t  st_reg;
   logic [2:0] valid_reg, sel_ins_reg, pairx_reg;

   function automatic logic ol(input int x, input int y, input logic [2:0] p,
                               input sws_desc_t h0, input sws_desc_t h1, input sws_desc_t h2);
      logic [TSW-1:0] tx, ty;
      tx = (x == 0) ? h0.ts : (x == 1) ? h1.ts : h2.ts;
      ty = (y == 0) ? h0.ts : (y == 1) ? h1.ts : h2.ts;
      ol = p[x] & (~p[y] | older(tx, ty));
   endfunction : ol

   always_comb begin
      sws_desc_t hi;
      logic      ip, mp, take;
      hi   = mem[SWS_Q_INS][rd_ptr[SWS_Q_INS]];
      ip   = (cnt[SWS_Q_INS] != '0);
      mp   = 1'b0;
      take = 1'b0;
      for (int k = 0; k < 3; k++) begin
         lh[k] = mem[k][rd_ptr[k]];
         mp    = (cnt[k] != '0);
         // Insertion head replaces the main head when older
         take  = (k != 1) && ip && (hi.cls == (k == 2)) &&
                 (!mp || older(hi.ts, lh[k].ts));
         lins[k] = take;
         pres[k] = mp | take;
         if (take) lh[k] = hi;
      end
   end

   assign ro_cp = lh[2].ro & ~rodis_reg;
   assign np_ok = ol(1, 0, pres, lh[0], lh[1], lh[2]) |
                  (ol(0, 2, pres, lh[0], lh[1], lh[2]) & ro_cp &
                   ol(2, 1, pres, lh[0], lh[1], lh[2]));
   // No posted head left: a lone completion must still drain
   assign cp_ok = ol(0, 2, pres, lh[0], lh[1], lh[2]) ?
                  (ro_cp & ol(1, 2, pres, lh[0], lh[1], lh[2])) :
                  (~pres[0] | ol(1, 0, pres, lh[0], lh[1], lh[2]));
   assign ok    = {cp_ok, np_ok, 1'b1};

   always_comb begin
      logic fit;
      fit = 1'b1;
      for (int k = 0; k < 3; k++) begin
         fit = 1'b1;
         for (int p = 0; p < NP; p++) begin
            if (lh[k].dest[p] && (INGRESS_WIDTH_IN < EGRESS_WIDTH_IN[4*p +: 4])) fit = 1'b0;
         end
         pair[k]  = ((PORT_ID == `SWS_UP_PORT)   && lh[k].dest[`SWS_PAIR_PORT]) ||
                    ((PORT_ID == `SWS_PAIR_PORT) && lh[k].dest[`SWS_UP_PORT]);
         cut[k]   = fit & ~(pair[k] & ppctd_reg);
         upblk[k] = (PORT_ID != `SWS_UP_PORT) && (PORT_ID != `SWS_PAIR_PORT) &&
                    lh[k].dest[`SWS_UP_PORT] && PAIR_BUSY_IN;
         // Peer traffic takes both buses through the one-TLP decoupler
         dcp[k]   = (PORT_ID != `SWS_UP_PORT) &&
                    ((lh[k].dest & ~onehot(`SWS_UP_PORT)) != '0);
         cand[k]  = pres[k] & ok[k] & (lh[k].done | cut[k]) &
                    ~(pair[k] & PAIR_REV_BUSY_IN) & ~upblk[k];
      end
      // Younger head yields when both aim at one port
      for (int a = 0; a < 3; a++) begin
         for (int b = 0; b < 3; b++) begin
            if (a != b && cand[a] && cand[b] && ((lh[a].dest & lh[b].dest) != '0) &&
                older(lh[b].ts, lh[a].ts)) cand[a] = 1'b0;
         end
      end
   end

   // ==========================================================
   // Dispatch and transfer tracking
   logic [2:0] gsel;
   assign gsel   = GRANT_IN & valid_reg;
   assign pop_en = (st_reg == SWS_IDLE) && (gsel != '0);
   always_comb begin
      pop_q = 2'h0;
      for (int k = 2; k >= 0; k--) begin
         if (gsel[k]) pop_q = sel_ins_reg[k] ? 2'h3 : 2'(k);
      end
   end

   // Busy blocks any new grant so the egress stream is never cut
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         st_reg        <= SWS_IDLE;
         XFER_BUSY_OUT <= 1'b0;
         PAIR_XFER_OUT <= 1'b0;
      end else begin
         case (st_reg)
            SWS_IDLE: if (pop_en) begin
               st_reg        <= SWS_BUSY;
               XFER_BUSY_OUT <= 1'b1;
               PAIR_XFER_OUT <= |(gsel & pairx_reg);
            end
            SWS_BUSY: if (EGRESS_END_IN) begin
               st_reg        <= SWS_IDLE;
               XFER_BUSY_OUT <= 1'b0;
               PAIR_XFER_OUT <= 1'b0;
            end
            default: begin
               st_reg        <= SWS_IDLE;
               XFER_BUSY_OUT <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         valid_reg     <= '0;
         sel_ins_reg   <= '0;
         pairx_reg     <= '0;
         HEAD_DEST_OUT <= '0;
         HEAD_SIZE_OUT <= '0;
         HEAD_AGE_OUT  <= '0;
         HEAD_CUT_OUT  <= '0;
         HEAD_DCP_OUT  <= '0;
      end else begin
         valid_reg   <= (st_reg == SWS_IDLE && !pop_en) ? cand : 3'h0;
         sel_ins_reg <= lins;
         pairx_reg   <= pair;
         HEAD_CUT_OUT <= cut;
         HEAD_DCP_OUT <= dcp;
         for (int k = 0; k < 3; k++) begin
            HEAD_DEST_OUT[NP*k +: NP]  <= lh[k].dest;
            HEAD_SIZE_OUT[10*k +: 10]  <= lh[k].size;
            HEAD_AGE_OUT[TSW*k +: TSW] <= lh[k].ts;
         end
      end
   end
   assign HEAD_VALID_OUT = valid_reg;

   // ==========================================================
   // Checks
   logic [TSW-1:0] last_ts_reg;
   logic           had_enq_reg;
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         last_ts_reg <= '0;
         had_enq_reg <= 1'b0;
      end else if (enq) begin
         last_ts_reg <= ts_reg;
         had_enq_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN);

   AST_TS_TICK: assert property (!$past(RESET_IN) |-> ts_reg == $past(ts_reg) + 1'b1)
      else $error("timestamp did not advance");
   AST_TS_UNIQUE: assert property (enq && had_enq_reg |-> ts_reg != last_ts_reg)
      else $error("duplicate timestamp");
   AST_STORE_FWD: assert property (valid_reg[0] && !HEAD_CUT_OUT[0] |-> $past(lh[0].done))
      else $error("incomplete TLP offered without cut-through");
   AST_CUT_WIDTH: assert property (cut[0] && lh[0].dest[0] |->
                                   INGRESS_WIDTH_IN >= EGRESS_WIDTH_IN[3:0])
      else $error("cut-through to wider egress");
   AST_BUSY_QUIET: assert property (st_reg == SWS_BUSY |=> valid_reg == 3'h0)
      else $error("head offered during transfer");
   AST_BUSY_HOLD: assert property (pop_en |=> st_reg == SWS_BUSY)
      else $error("transfer not tracked");
   AST_PAIR_SF: assert property (pair[0] && ppctd_reg |=> !HEAD_CUT_OUT[0])
      else $error("pair cut-through while disabled");
   AST_PAIR_DIR: assert property (pair[1] && PAIR_REV_BUSY_IN |=> !valid_reg[1])
      else $error("pair traffic both ways");
   AST_UP_BLOCK: assert property (upblk[0] |=> !valid_reg[0])
      else $error("upstream transfer during pair transfer");
   AST_NP_ORDER: assert property (valid_reg[1] |-> $past(np_ok))
      else $error("non-posted passed posted");
   AST_SAME_DEST: assert property (valid_reg[0] && valid_reg[2] |->
                                   (HEAD_DEST_OUT[NP-1:0] & HEAD_DEST_OUT[3*NP-1:2*NP]) == '0)
      else $error("two heads to one egress");
   AST_RO_DIS: assert property (rodis_reg |-> !ro_cp)
      else $error("relaxed ordering honoured while disabled");

   COV_GRANT_P:   cover property (pop_en && gsel[0]);
   COV_INS_MERGE: cover property (lins[2] && valid_reg[2]);
   COV_FIFO_FULL: cover property (IN_VALID_IN && !IN_READY_OUT);
   COV_PAIR_CUT:  cover property (pair[0] && cut[0]);
endmodule : sws_ingress
`default_nettype wire

// [sws_sched_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Core scheduler stand-in: grants one head, ends it later
module sws_sched_model (
   input  wire logic       clk_in,    // Core clock
   input  wire logic       rst_in,    // Async reset, high
   input  wire logic       en_in,     // Scheduling allowed
   input  wire logic       slow_in,   // Long egress transfers
   input  wire logic [2:0] valid_in,  // Dispatchable heads
   output logic      [2:0] grant_out, // One-hot grant pulse
   output logic            end_out    // Egress finished pulse
);
   int   cnt_reg;
   logic busy_reg;
   // Falling edge keeps grants clear of the sampling edge
   always_ff @(negedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         grant_out <= 3'h0;
         end_out   <= 1'b0;
         busy_reg  <= 1'b0;
         cnt_reg   <= 0;
      end else begin
         grant_out <= 3'h0;
         end_out   <= 1'b0;
         if (busy_reg) begin
            if (cnt_reg == 0) begin
               end_out  <= 1'b1;
               busy_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_reg - 1;
            end
         end else if (en_in && valid_in != 3'h0) begin
            grant_out <= valid_in[0] ? 3'h1 : (valid_in[1] ? 3'h2 : 3'h4);
            busy_reg  <= 1'b1;
            cnt_reg   <= slow_in ? 12 : 1;
         end
      end
   end
endmodule : sws_sched_model
`default_nettype wire

// [switch_ingress_ordering_forwarding_test.sv]
`timescale 1ns/1ps
`default_nettype none
module switch_ingress_ordering_forwarding_test;
   logic        clk = 0, rst = 1, vld = 0, ro = 0, ins_cp = 0, pme = 0, sw_wr = 0, sw_d = 0;
   logic        en = 0, slow = 0, zero = 0, pbusy = 0, ok;
   logic [1:0]  q = 0, dst = 0;
   logic [2:0]  rt = 0;
   logic [9:0]  sz = 0;
   logic [3:0]  done = 0, iw = 4'h4;
   logic [15:0] ew = 16'h4444;
   logic [2:0]  grant, hv, hc, hdcp;
   logic        end_p, rdy, busy, lterm, pxf;
   logic [11:0] hd;
   logic [29:0] hs;
   logic [47:0] ha;
   logic [9:0]  gsz[$];
   int          num_errors = 0, n_compared = 0, n_grant = 0, k, g0, acc;

   sws_ingress #(.QDEPTH(4)) uut (.CLK_SYS_IN(clk), .RESET_IN(rst), .IN_VALID_IN(vld),
      .IN_READY_OUT(rdy), .IN_QUEUE_IN(q), .IN_ROUTE_IN(rt), .IN_DEST_IN(dst), .IN_SIZE_IN(sz),
      .IN_RO_IN(ro), .IN_INS_CP_IN(ins_cp), .IN_PME_ACK_IN(pme), .IN_DONE_IN(done),
      .CT_CTRL_WR_IN(zero), .CT_CTRL_DATA_IN(zero), .SW_CTRL_WR_IN(sw_wr),
      .SW_CTRL_DATA_IN(sw_d), .INGRESS_WIDTH_IN(iw), .EGRESS_WIDTH_IN(ew),
      .PAIR_REV_BUSY_IN(pbusy), .PAIR_BUSY_IN(pbusy), .GRANT_IN(grant), .EGRESS_END_IN(end_p),
      .HEAD_VALID_OUT(hv), .HEAD_DEST_OUT(hd), .HEAD_SIZE_OUT(hs), .HEAD_AGE_OUT(ha),
      .HEAD_CUT_OUT(hc), .HEAD_DCP_OUT(hdcp), .XFER_BUSY_OUT(busy), .PAIR_XFER_OUT(pxf),
      .LOCAL_TERM_OUT(lterm));
   sws_sched_model sched (.clk_in(clk), .rst_in(rst), .en_in(en), .slow_in(slow),
      .valid_in(hv), .grant_out(grant), .end_out(end_p));

   always #2.5 clk = ~clk;
   // Head size is read before the pop lands, so it names the granted TLP
   always @(posedge clk) if (grant != 3'h0) begin
      n_grant++;
      if (grant[0]) gsz.push_back(hs[9:0]);
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n

   task automatic send(input logic [1:0] tq, input logic [2:0] tr, input logic [1:0] td,
                       input logic [9:0] ts, input logic tro, output logic tok);
      int n;
      n = 0;
      @(negedge clk);
      {vld, q, rt, dst, sz, ro} = {1'b1, tq, tr, td, ts, tro};
      while (rdy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      tok = (rdy === 1'b1);
      // Held through the edge that takes it, dropped on a refusal
      if (tok) @(negedge clk);
      vld = 0;
   endtask : send

   task automatic drain_to(input int g);
      int n;
      n = 0;
      en = 1;
      while ((n_grant < g || busy !== 1'b0) && n < 600) begin
         @(negedge clk);
         n++;
         if (busy === 1'b1) check({hv, pxf}, 4'h0);
      end
      check(n_grant, g);
      en = 0;
      wait_n(4);
   endtask : drain_to

   task automatic ord(input logic [1:0] a, b, c, input int n, input logic cro, same,
                      input logic [2:0] exp);
      logic [1:0] t[3];
      logic       tok;
      t = '{a, b, c};
      for (int i = 0; i < n; i++)
         send(t[i], 3'h0, same ? 2'h3 : (t[i] == 2'h2 ? 2'h3 : t[i]), 10'(i + 1),
              cro && t[i] == 2'h2, tok);
      wait_n(8);
      check(hv, exp);
      check(ha[16*a+:16] < ha[16*b+:16], 1'b1);
      drain_to(n_grant + n);
   endtask : ord

   task automatic set_rodis(input logic v);
      @(negedge clk);
      {sw_wr, sw_d} = {1'b1, v};
      @(negedge clk);
      sw_wr = 0;
   endtask : set_rodis

   // ==========================================================
   // Scenarios
   task automatic test_reset();
      wait_n(5);
      check({rdy, hv, busy, lterm}, 6'h0);
      rst = 0;
      wait_n(2);
      check(rdy, 1'b1);
      $display("reset test done");
   endtask : test_reset

   task automatic test_forward();
      ew[15:12] = 4'h8;
      send(2'h0, 3'h0, 2'h3, 10'h010, 1'b0, ok);
      wait_n(8);
      check({hv[0], hc[0]}, 2'b00);
      @(negedge clk) done = 4'h1;
      @(negedge clk) done = 4'h0;
      wait_n(6);
      check({hv[0], hc[0], hd[3:0], hs[9:0]}, {2'b10, 4'h8, 10'h010});
      check(hdcp[0], 1'b1);
      drain_to(n_grant + 1);
      ew[15:12] = 4'h4;
      iw = 4'h8;
      send(2'h0, 3'h0, 2'h1, 10'h020, 1'b0, ok);
      wait_n(8);
      check({hv[0], hc[0], hd[3:0]}, {2'b11, 4'h2});
      drain_to(n_grant + 1);
      iw = 4'h4;
      $display("forwarding mode test done");
   endtask : test_forward

   // Port 2 is no pair member: only its upstream-bound head must wait
   task automatic test_pair();
      pbusy = 1;
      send(2'h1, 3'h0, 2'h3, 10'h007, 1'b0, ok);
      send(2'h0, 3'h0, 2'h0, 10'h008, 1'b0, ok);
      wait_n(8);
      check(hv, 3'b010);
      check(hdcp[1:0], 2'b10);
      pbusy = 0;
      wait_n(4);
      check(hv, 3'b011);
      drain_to(n_grant + 2);
      $display("pair block test done");
   endtask : test_pair

   task automatic test_order();
      ord(2'h0, 2'h1, 2'h2, 3, 1'b1, 1'b0, 3'b101);
      ord(2'h0, 2'h1, 2'h2, 3, 1'b0, 1'b0, 3'b001);
      ord(2'h0, 2'h2, 2'h1, 3, 1'b1, 1'b0, 3'b011);
      ord(2'h1, 2'h0, 2'h2, 3, 1'b0, 1'b0, 3'b011);
      ord(2'h1, 2'h2, 2'h0, 3, 1'b0, 1'b0, 3'b111);
      ord(2'h2, 2'h0, 2'h1, 3, 1'b0, 1'b0, 3'b001);
      ord(2'h2, 2'h1, 2'h0, 3, 1'b0, 1'b0, 3'b111);
      ord(2'h1, 2'h0, 2'h0, 2, 1'b0, 1'b1, 3'b010);
      set_rodis(1'b1);
      ord(2'h0, 2'h1, 2'h2, 3, 1'b1, 1'b0, 3'b001);
      set_rodis(1'b0);
      $display("ordering test done");
   endtask : test_order

   task automatic test_insert();
      for (int c = 0; c < 2; c++) begin
         ins_cp = c[0];
         send(2'h3, 3'h0, 2'h3, 10'h005, 1'b0, ok);
         wait_n(8);
         check({hv, c ? hs[29:20] : hs[9:0]}, {(c ? 3'b100 : 3'b001), 10'h005});
         drain_to(n_grant + 1);
      end
      ins_cp = 0;
      $display("insertion test done");
   endtask : test_insert

   task automatic test_route();
      g0 = n_grant;
      en = 1;
      for (int r = 0; r < 8; r++) begin
         pme = (r == 7);
         send(2'h0, 3'(r), 2'h2, 10'(r + 1), 1'b0, ok);
         k = 0;
         repeat (8) begin
            @(negedge clk);
            if (lterm === 1'b1) k++;
         end
         check(k, (r == 5 || r == 6) ? 1 : 0);
      end
      pme = 0;
      drain_to(g0 + 6);
      $display("routing test done");
   endtask : test_route

   task automatic test_fill();
      gsz.delete();
      acc = 0;
      for (int i = 1; i <= 12; i++) begin
         send(2'h0, 3'h0, 2'h3, 10'(i), 1'b0, ok);
         if (ok) acc++;
      end
      check(acc, 8);
      slow = 1;
      drain_to(n_grant + 8);
      slow = 0;
      for (int i = 0; i < 8; i++) check(gsz[i], 10'(i + 1));
      $display("buffer fill test done");
   endtask : test_fill

   // ==========================================================
   // Main sequence
   initial begin
      fork
         begin
            repeat (20000) @(posedge clk);
            num_errors++;
            give_verdict();
         end
      join_none
      test_reset();
      test_forward();
      test_order();
      test_pair();
      test_insert();
      test_route();
      test_fill();
      give_verdict();
   end
endmodule : switch_ingress_ordering_forwarding_test
`default_nettype wire
